// ### src/cal_consts.vh
`ifndef CAL_CONSTS_VH
`define CAL_CONSTS_VH

// ---------------------------------------------------------------
// register word offsets (byte addresses)
// ---------------------------------------------------------------
`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h04
`define IRQ_STAT_ADDR 8'h08
`define IRQ_MASK_ADDR 8'h0C
`define TRIM_BASE_WORD 6'h10
`define TRIM_COUNT 24
`define TRIM_LAST_IDX 5'h17

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTRL_SRC_SEL 0
`define CTRL_SOFT_TRIG 1
`define CTRL_BG_EN 2
`define CTRL_FG_OFS 3
`define CTRL_BG_OFS 4
`define CTRL_RESET 5'h00

// ---------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------
`define IRQ_FOREGROUND_COMPLETE_FLAG 0
`define IRQ_SWAP 1

// ---------------------------------------------------------------
// trim word fields and reset value
// ---------------------------------------------------------------
`define TRIM_OFS_LSB 0
`define TRIM_GAIN_LSB 8
`define TRIM_TERM_LSB 16
`define TRIM_RESET 24'h804080

// ---------------------------------------------------------------
// data and timing
// ---------------------------------------------------------------
`define MID_CODE 12'h000
`define CLK_PERIOD_NS 50
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define FG_CAL_TIME_US 100
`define FG_OFS_TIME_US 20
`define BG_SLOT_TIME_US 50
`define FG_CAL_TICKS (`FG_CAL_TIME_US * 1000 / `TICK_NS)
`define FG_OFS_TICKS (`FG_OFS_TIME_US * 1000 / `TICK_NS)
`define BG_SLOT_TICKS (`BG_SLOT_TIME_US * 1000 / `TICK_NS)

`endif

// ### src/pin_sync3.v
`timescale 1ns/100ps
// three-stage pin synchroniser; output follows once stages 2 and 3 agree
module pin_sync3 (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // asynchronous pin and clean level
  input wire pin_in,
  output reg level_out
);
  reg meta_reg; // first stage, read only by second
  reg s2_reg;   // second stage
  reg s3_reg;   // third stage

  // ---------------------------------------------------------------
  // shift chain and agreement filter
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      // one-cycle glitches between stages are not passed on
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule

// ### src/cal_sequencer.v
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "cal_consts.vh"
module cal_sequencer (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // trigger pin from host
  input wire cal_trigger_pin,
  // converter cores and offset estimator
  input wire [71:0] core_data_in,
  input wire [31:0] ofs_estimate,
  // channel data and core control
  output reg [47:0] ch_data_out,
  output reg [5:0] core_offline,
  output reg [5:0] core_cal_active,
  output wire [575:0] trim_out,
  // interrupt
  output wire irq
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [1:0] ST_FG_CAL = 2'b00;
  localparam [1:0] ST_FG_OFS = 2'b01;
  localparam [1:0] ST_IDLE = 2'b10;
  localparam [1:0] ST_BG = 2'b11;
  localparam integer TICK_LAST_N = `TICK_CYCLES - 1;
  localparam integer FG_CAL_LAST_N = `FG_CAL_TICKS - 1;
  localparam integer FG_OFS_LAST_N = `FG_OFS_TICKS - 1;
  localparam integer BG_SLOT_LAST_N = `BG_SLOT_TICKS - 1;
  // counts fit their counters; the part-selects drop the spare bits
  localparam [4:0] TICK_LAST = TICK_LAST_N[4:0];
  localparam [7:0] FG_CAL_LAST = FG_CAL_LAST_N[7:0];
  localparam [7:0] FG_OFS_LAST = FG_OFS_LAST_N[7:0];
  localparam [7:0] BG_SLOT_LAST = BG_SLOT_LAST_N[7:0];

  reg [4:0] ctrl_reg;        // software control bits
  reg [1:0] irq_stat_reg;    // sticky events
  reg [1:0] irq_mask_reg;    // interrupt enables
  reg [23:0] trim_reg [0:23]; // trims, index = input*6 + core
  reg done_reg;              // foreground complete flag
  reg [1:0] state_reg;       // sequencer state
  reg [1:0] state_next;
  reg slot_reg;              // background slot: 0 first, 1 second
  reg [4:0] div_reg;         // 1 us tick divider
  reg tick;                  // one-cycle enable every microsecond
  reg [7:0] tmr_reg;         // elapsed ticks in current phase
  reg soft_prev_reg;         // soft trigger, last cycle
  reg pin_prev_reg;          // synchronised pin, last cycle
  wire pin_lvl;              // synchronised trigger pin
  reg wr_pend_reg;           // write data phase pending
  reg [5:0] wa_reg;          // word address of pending write
  wire [5:0] wa;             // word address of address phase
  wire addr_ok;              // upper address bits clear
  wire [4:0] trim_idx;       // trim index of address phase
  wire [4:0] wtrim_idx;      // trim index of pending write
  wire [5:0] trim_off;       // word offset into the trim block
  wire [5:0] wtrim_off;      // same, for the pending write
  wire is_trim;
  wire w_is_trim;
  wire trig_edge;
  wire bg_cond;
  wire fg_start;
  wire fg_end;
  wire swap;
  wire ofs_apply;
  integer i;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // zero wait states, so every transfer is answered at once
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wa = haddr[7:2];
  assign addr_ok = (haddr[31:8] == 24'h000000);
  assign trim_off = wa - `TRIM_BASE_WORD;
  assign wtrim_off = wa_reg - `TRIM_BASE_WORD;
  assign trim_idx = trim_off[4:0];
  assign wtrim_idx = wtrim_off[4:0];
  // the trim block reaches past word 0x1F, so bit 5 may be set
  assign is_trim = addr_ok && (wa >= `TRIM_BASE_WORD) &&
                   (trim_off <= {1'b0, `TRIM_LAST_IDX});
  assign w_is_trim = (wa_reg >= `TRIM_BASE_WORD) &&
                     (wtrim_off <= {1'b0, `TRIM_LAST_IDX});

  // capture address phase of a write; reads answer from address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 6'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite && addr_ok;
      wa_reg <= wa;
      hrdata <= 32'h00000000;
      if (hsel && htrans[1] && !hwrite) begin
        if (is_trim) begin
          hrdata <= {8'h00, trim_reg[trim_idx]};
        end else if (addr_ok) begin
          case ({wa, 2'b00})
            `CTRL_ADDR: hrdata <= {27'h0000000, ctrl_reg};
            `STAT_ADDR: hrdata <= {26'h0000000, core_cal_active[0],
                                   slot_reg, state_reg, 1'b0, done_reg};
            `IRQ_STAT_ADDR: hrdata <= {30'h00000000, irq_stat_reg};
            `IRQ_MASK_ADDR: hrdata <= {30'h00000000, irq_mask_reg};
            default: hrdata <= 32'h00000000; // unmapped reads zero
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // control, mask and sticky status registers
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CTRL_RESET;
      irq_mask_reg <= 2'b00;
      irq_stat_reg <= 2'b00;
    end else begin
      if (wr_pend_reg && ({wa_reg, 2'b00} == `CTRL_ADDR)) begin
        ctrl_reg <= hwdata[4:0];
      end
      if (wr_pend_reg && ({wa_reg, 2'b00} == `IRQ_MASK_ADDR)) begin
        irq_mask_reg <= hwdata[1:0];
      end
      // a new event wins over a write-one-to-clear in the same cycle
      if (wr_pend_reg && ({wa_reg, 2'b00} == `IRQ_STAT_ADDR)) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[1:0]) | {swap, fg_end};
      end else begin
        irq_stat_reg <= irq_stat_reg | {swap, fg_end};
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // trim store
  // ---------------------------------------------------------------
  // offset correction overrides a software write to the offset field;
  // software must not write offsets while offset calibration is used
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < `TRIM_COUNT; i = i + 1) begin
        trim_reg[i] <= `TRIM_RESET;
      end
    end else begin
      if (wr_pend_reg && w_is_trim) begin
        trim_reg[wtrim_idx] <= hwdata[23:0];
      end
      if (ofs_apply) begin
        for (i = 0; i < `TRIM_COUNT; i = i + 1) begin
          // each input's estimate goes to all six cores of that input
          trim_reg[i][`TRIM_OFS_LSB +: 8] <=
            ofs_estimate[(i / 6) * 8 +: 8];
        end
      end
    end
  end

  // flat trim output to the analog side
  genvar g;
  generate
    for (g = 0; g < `TRIM_COUNT; g = g + 1) begin : trim_map
      assign trim_out[g * 24 +: 24] = trim_reg[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // triggers
  // ---------------------------------------------------------------
  pin_sync3 trig_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(cal_trigger_pin),
    .level_out(pin_lvl)
  );

  // remember last trigger levels for edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_prev_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      soft_prev_reg <= ctrl_reg[`CTRL_SOFT_TRIG];
      pin_prev_reg <= pin_lvl;
    end
  end

  // only the selected source counts; the other is ignored
  assign trig_edge = ctrl_reg[`CTRL_SRC_SEL] ?
    (pin_lvl && !pin_prev_reg) :
    (ctrl_reg[`CTRL_SOFT_TRIG] && !soft_prev_reg);
  assign bg_cond = ctrl_reg[`CTRL_BG_EN] && !ctrl_reg[`CTRL_SRC_SEL] &&
                   ctrl_reg[`CTRL_SOFT_TRIG];
  // with background armed, the soft edge starts background instead
  assign fg_start = trig_edge && !bg_cond &&
                    (state_reg == ST_IDLE || state_reg == ST_BG);

  // ---------------------------------------------------------------
  // microsecond tick divider
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 5'h00;
      tick <= 1'b0;
    end else begin
      tick <= (div_reg == TICK_LAST);
      div_reg <= (div_reg == TICK_LAST) ? 5'h00 : div_reg + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign fg_end = tick && ((state_reg == ST_FG_CAL && tmr_reg == FG_CAL_LAST &&
                  !ctrl_reg[`CTRL_FG_OFS]) ||
                  (state_reg == ST_FG_OFS && tmr_reg == FG_OFS_LAST));
  assign swap = tick && state_reg == ST_BG && tmr_reg == BG_SLOT_LAST;
  // foreground offset applied once at the end of its pass
  assign ofs_apply = (tick && state_reg == ST_FG_OFS &&
                      tmr_reg == FG_OFS_LAST) ||
                     (swap && ctrl_reg[`CTRL_BG_OFS]);

  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_FG_CAL: begin
        if (tick && tmr_reg == FG_CAL_LAST) begin
          state_next = ctrl_reg[`CTRL_FG_OFS] ? ST_FG_OFS : ST_IDLE;
        end
      end
      ST_FG_OFS: begin
        if (fg_end) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fg_start) begin
          state_next = ST_FG_CAL;
        end else if (bg_cond) begin
          state_next = ST_BG;
        end
      end
      ST_BG: begin
        if (fg_start) begin
          state_next = ST_FG_CAL;
        end else if (!bg_cond) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // state, timer, slot and done flag; reset state is foreground
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_FG_CAL;
      tmr_reg <= 8'h00;
      slot_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || swap) begin
        tmr_reg <= 8'h00;
      end else if (tick) begin
        tmr_reg <= tmr_reg + 8'h01;
      end
      if (swap) begin
        slot_reg <= ~slot_reg;
      end else if (state_reg != ST_BG) begin
        slot_reg <= 1'b0;
      end
      if (fg_start) begin
        done_reg <= 1'b0;
      end else if (fg_end) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // core control
  // ---------------------------------------------------------------
  // background takes out core 0 and 4 in slot 0, 1 and 5 in slot 1;
  // spares 2 and 3 stand in, so only one core per pair is offline
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_offline <= 6'h3F;
      core_cal_active <= 6'h3F;
    end else begin
      // decoded from the current state, in step with the channel data
      case (state_reg)
        ST_FG_CAL, ST_FG_OFS: begin
          core_offline <= 6'h3F;
          core_cal_active <= 6'h3F;
        end
        ST_BG: begin
          core_offline <= slot_reg ? 6'h22 : 6'h11;
          core_cal_active <= slot_reg ? 6'h22 : 6'h11;
        end
        default: begin
          core_offline <= 6'h00;
          core_cal_active <= 6'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // channel data path
  // ---------------------------------------------------------------
  // channel k is served by core 0,1,4,5; spare 2 or 3 when replaced
  generate
    for (g = 0; g < 4; g = g + 1) begin : ch_map
      localparam integer MAIN = (g < 2) ? g : g + 2;
      localparam integer SPARE = (g < 2) ? 2 : 3;
      localparam LOWER = (g == 0 || g == 2);
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ch_data_out[g * 12 +: 12] <= `MID_CODE;
        end else if (state_reg == ST_FG_CAL || state_reg == ST_FG_OFS) begin
          ch_data_out[g * 12 +: 12] <= `MID_CODE;
        end else if (state_reg == ST_BG && (slot_reg != LOWER)) begin
          ch_data_out[g * 12 +: 12] <=
            core_data_in[SPARE * 12 +: 12];
        end else begin
          ch_data_out[g * 12 +: 12] <= core_data_in[MAIN * 12 +: 12];
        end
      end
    end
  endgenerate

  // hsize is always a word here; narrower accesses are not decoded
  wire unused_hsize;
  assign unused_hsize = ^hsize;
endmodule

// ### tb/host_model.sv
`timescale 1ns/100ps
// host side: trigger pin, core samples and offset estimates
module host_model (
  // clock
  input wire hclk,
  // pin request from the bench
  input wire pin_req,
  // toward the sequencer
  output reg cal_trigger_pin,
  output wire [71:0] core_data_in,
  output wire [31:0] ofs_estimate
);
  genvar g;
  // ---------------------------------------------------------------
  // core samples
  // ---------------------------------------------------------------
  // each core shows its number plus one in the top nibble; kept steady so
  // a swap shows up as a plain change of value
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_core
      localparam [3:0] CORE_TAG = g + 1;
      assign core_data_in[g*12 +: 12] = {CORE_TAG, 8'hA0};
    end
  endgenerate
  // offset estimates: inputs held away from dc, so each estimate
  // is a steady, nonzero byte
  assign ofs_estimate = 32'h44332211;
  // ---------------------------------------------------------------
  // trigger pin
  // ---------------------------------------------------------------
  // pin follows the request one edge late; the bench only asks once the
  // power-up calibration has finished
  initial cal_trigger_pin = 1'b0;
  always @(posedge hclk) begin
    cal_trigger_pin <= pin_req;
  end
endmodule

// ### tb/cal_checker.sv
`timescale 1ns/100ps
// port-level checks of the calibration sequencer
module cal_checker (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // cores and channels
  input wire [71:0] core_data_in,
  input wire [47:0] ch_data_out,
  input wire [5:0] core_offline,
  input wire [5:0] core_cal_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // helper: length of the all-offline stretch
  // ---------------------------------------------------------------
  reg [11:0] fg_cnt_reg;
  // saturates so a stuck calibration cannot wrap back into range
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fg_cnt_reg <= 12'h000;
    end else if (core_offline != 6'h3F) begin
      fg_cnt_reg <= 12'h000;
    end else if (fg_cnt_reg != 12'hFFF) begin
      fg_cnt_reg <= fg_cnt_reg + 12'h001;
    end
  end
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence fg_leave;
    $past(core_offline) == 6'h3F ##0 core_offline != 6'h3F;
  endsequence
  sequence slot_held(logic [5:0] v);
    core_offline == v ##1 core_offline == v;
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  AST_READY_HIGH: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  AST_HRDATA_IDLE: assert property (
    !(hsel && htrans[1] && hready) |=> hrdata == 32'h00000000)
    else $error("read data stands outside a data phase");
  AST_FG_MID_CODE: assert property (
    core_offline == 6'h3F |-> ch_data_out == 48'h000000000000)
    else $error("channels not at mid-code while cores offline");
  AST_CAL_MATCH: assert property (core_cal_active == core_offline)
    else $error("calibrating cores differ from offline cores");
  AST_BG_PAIRS: assert property (
    core_offline != 6'h3F |-> core_offline inside {6'h00, 6'h11, 6'h22})
    else $error("offline cores outside the spare pairing");
  AST_BG_SUBST: assert property (
    slot_held(6'h11) |-> ch_data_out[11:0] == $past(core_data_in[35:24])
      && ch_data_out[35:24] == $past(core_data_in[47:36]))
    else $error("spare cores not standing in for cores 0 and 4");
  AST_NORMAL_MAP: assert property (
    slot_held(6'h00) |-> ch_data_out == {$past(core_data_in[71:60]),
      $past(core_data_in[59:48]), $past(core_data_in[23:12]),
      $past(core_data_in[11:0])})
    else $error("channels not fed from cores 0 1 4 5");
  AST_FG_LENGTH: assert property (
    fg_leave |-> fg_cnt_reg inside {[12'd1900:12'd2500]})
    else $error("foreground calibration length out of range");
  COV_SLOT1: cover property (slot_held(6'h22));
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
`include "cal_consts.vh"
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h00000000;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h00000000;
  reg pin_req = 1'b0;
  wire hready;
  wire hresp;
  wire irq;
  wire cal_trigger_pin;
  wire [31:0] hrdata;
  wire [71:0] core_data_in;
  wire [31:0] ofs_estimate;
  wire [47:0] ch_data_out;
  wire [5:0] core_offline;
  wire [5:0] core_cal_active;
  wire [575:0] trim_out;
  integer errors = 0;
  integer cmp_count = 0;
  reg [31:0] rd;
  always #25 hclk = ~hclk;
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  cal_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .cal_trigger_pin(cal_trigger_pin),
    .core_data_in(core_data_in), .ofs_estimate(ofs_estimate),
    .ch_data_out(ch_data_out), .core_offline(core_offline),
    .core_cal_active(core_cal_active), .trim_out(trim_out), .irq(irq));
  host_model i_host (.hclk(hclk), .pin_req(pin_req),
    .cal_trigger_pin(cal_trigger_pin), .core_data_in(core_data_in),
    .ofs_estimate(ofs_estimate));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task stop_test;
    begin
      $display("TB counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task check(input [47:0] seen, input [47:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // one single transfer; bounded waits on hready in both phases
  task bus(input [7:0] a, input w, input [31:0] wd);
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge hclk);
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge hclk);
      end
      rd = hrdata;
      if (n >= 50) begin
        errors = errors + 1;
        stop_test;
      end
    end
  endtask
  // polls the done flag; a stuck calibration ends the run
  task wait_done;
    integer n;
    begin
      n = 0;
      rd = 32'h00000000;
      while (rd[0] !== 1'b1 && n < 1500) begin
        bus(`STAT_ADDR, 1'b0, 32'h0);
        n = n + 1;
      end
      if (n >= 1500) begin
        errors = errors + 1;
        stop_test;
      end
    end
  endtask
  // waits for a given offline pattern, then lets outputs settle
  task wait_offline(input [5:0] v);
    integer n;
    begin
      n = 0;
      while (core_offline !== v && n < 2500) begin
        @(posedge hclk);
        n = n + 1;
      end
      if (n >= 2500) begin
        errors = errors + 1;
        stop_test;
      end
      @(posedge hclk);
      #1;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_powerup;
    begin
      check(core_offline, 6'h3F);
      check(ch_data_out, 48'h0);
      wait_done;
      check(rd[0], 1'b1);
      wait_offline(6'h00);
      check(ch_data_out, 48'h6A05A02A01A0);
      bus(`IRQ_STAT_ADDR, 1'b0, 32'h0);
      check(rd[1:0], 2'h1);
      check(irq, 1'b0);
      bus(`IRQ_MASK_ADDR, 1'b1, 32'h3);
      #1 check(irq, 1'b1);
      bus(`IRQ_STAT_ADDR, 1'b1, 32'h1);
      #1 check(irq, 1'b0);
      $display("TB test powerup done");
    end
  endtask
  task t_regs;
    begin
      bus(8'h40, 1'b0, 32'h0);
      check(rd, 32'h00804080);
      bus(8'h9C, 1'b0, 32'h0);
      check(rd, 32'h00804080);
      bus(8'h44, 1'b1, 32'h00123456);
      bus(8'h44, 1'b0, 32'h0);
      check(rd, 32'h00123456);
      check(trim_out[47:24], 24'h123456);
      bus(8'h48, 1'b0, 32'h0);
      check(rd, 32'h00804080);
      bus(8'hFC, 1'b1, 32'hFFFFFFFF);
      bus(8'hFC, 1'b0, 32'h0);
      check(rd, 32'h0);
      $display("TB test registers done");
    end
  endtask
  // soft trigger, then a soft edge while the pin is selected
  task t_soft;
    begin
      bus(`CTRL_ADDR, 1'b1, 32'h02);
      wait_offline(6'h3F);
      check(ch_data_out, 48'h0);
      bus(`STAT_ADDR, 1'b0, 32'h0);
      check(rd[0], 1'b0);
      wait_done;
      bus(`CTRL_ADDR, 1'b1, 32'h01);
      bus(`CTRL_ADDR, 1'b1, 32'h03);
      repeat (20) @(posedge hclk);
      #1 check(core_offline, 6'h00);
      $display("TB test soft trigger done");
    end
  endtask
  // pin ignored while the software bit is selected, then honoured
  task t_pin;
    begin
      bus(`CTRL_ADDR, 1'b1, 32'h00);
      pin_req <= 1'b1;
      repeat (8) @(posedge hclk);
      pin_req <= 1'b0;
      repeat (8) @(posedge hclk);
      #1 check(core_offline, 6'h00);
      bus(`CTRL_ADDR, 1'b1, 32'h01);
      pin_req <= 1'b1;
      wait_offline(6'h3F);
      pin_req <= 1'b0;
      check(ch_data_out, 48'h0);
      wait_done;
      $display("TB test pin trigger done");
    end
  endtask
  // offset pass once inside foreground; keeps gain and termination
  task t_offset;
    begin
      bus(`CTRL_ADDR, 1'b1, 32'h08);
      bus(`CTRL_ADDR, 1'b1, 32'h0A);
      wait_done;
      bus(8'h44, 1'b0, 32'h0);
      check(rd, 32'h00123411);
      bus(8'h40 + 8'd72, 1'b0, 32'h0);
      check(rd, 32'h00804044);
      $display("TB test offset done");
    end
  endtask
  // background with offset reload at each swap; trim 0 offset cleared
  // first so the reload is visible
  task t_bg;
    begin
      bus(`CTRL_ADDR, 1'b1, 32'h00);
      bus(8'h40, 1'b1, 32'h00804000);
      bus(`CTRL_ADDR, 1'b1, 32'h16);
      bus(`STAT_ADDR, 1'b0, 32'h0);
      check(rd[3:2], 2'h3);
      wait_offline(6'h11);
      check(ch_data_out, 48'h6A04A02A03A0);
      wait_offline(6'h22);
      check(ch_data_out, 48'h4A05A03A01A0);
      bus(`IRQ_STAT_ADDR, 1'b0, 32'h0);
      check(rd[1], 1'b1);
      check(irq, 1'b1);
      bus(8'h40, 1'b0, 32'h0);
      check(rd, 32'h00804011);
      $display("TB test background done");
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    t_powerup;
    t_regs;
    t_soft;
    t_pin;
    t_offset;
    t_bg;
    stop_test;
  end
endmodule
bind cal_sequencer cal_checker i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .core_data_in(core_data_in),
  .ch_data_out(ch_data_out), .core_offline(core_offline),
  .core_cal_active(core_cal_active));
